// >>> rtl/system_clock_select_and_fast_rc_control.sv
// System clock select, halt power modes and fast RC oscillator control with an APB slave.
// Assumes oscillator clocks and the analog ready level arrive as asynchronous pins,
// while halt and wake requests come from CPU logic on pclk.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module system_clock_select_and_fast_rc_control
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_fast_rc_osc,
  input wire logic external_fast_crystal,
  input wire logic internal_slow_rc_osc,
  input wire logic external_slow_crystal,
  input wire logic fast_rc_ready,
  input wire logic halt_req,
  input wire logic wake_req,
  output logic sys_tick,
  output logic fast_rc_osc_run,
  output logic [1:0] fast_rc_freq_out,
  output logic fast_xtal_run,
  output logic slow_rc_run,
  output logic slow_xtal_run,
  output logic cpu_halted,
  output clk_ctrl_pkg::mode_t power_mode,
  output logic irq
);
  import clk_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta, pin_sync, pin_last;
  logic [3:0] osc_edge;
  logic ready_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_last <= 5'h00;
    end
    else
    begin
      pin_meta <= {fast_rc_ready, external_slow_crystal, internal_slow_rc_osc,
                   external_fast_crystal, internal_fast_rc_osc};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign osc_edge = pin_sync[3:0] & ~pin_last[3:0];
  assign ready_sync = pin_sync[4];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] sys_clock_control, next_sys_clock_control;
  logic fast_rc_osc_enable, next_fast_rc_osc_enable;
  logic [1:0] fast_rc_freq_select, next_fast_rc_freq_select;
  logic fast_rc_stable_flag, next_fast_rc_stable_flag;
  logic [7:0] settle_cnt, next_settle_cnt;
  logic [1:0] next_fast_rc_freq_out;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic next_irq;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic wr_commit, rd_setup, addr_ok;
  logic [IRQ_W-1:0] events;
  logic restart;
  logic [4:0] cfg_active;
  logic switch_done;
  logic [7:0] fast_rc_control;

  // Read view of the fast RC register; upper bits are constant zero.
  always_comb
  begin
    fast_rc_control = 8'h00;
    fast_rc_control[FREQ_HI:FREQ_LO] = fast_rc_freq_select;
    fast_rc_control[FLAG_BIT] = fast_rc_stable_flag;
    fast_rc_control[EN_BIT] = fast_rc_osc_enable;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready comes from a flop, so reads are registered too.
  assign wr_commit = psel && penable && pready && pwrite;
  assign rd_setup = psel && penable && !pready;

  always_comb
  begin
    addr_ok = (paddr == OFS_SYS_CLK_CTRL) || (paddr == OFS_FAST_RC_CTRL) ||
              (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK) ||
              (paddr == OFS_CLK_STATE);
    next_pready = rd_setup;
    next_pslverr = rd_setup && !addr_ok;
    next_prdata = 32'h00000000;
    if (rd_setup && !pwrite)
    begin
      case (paddr)
        OFS_SYS_CLK_CTRL:
        begin
          next_prdata[7:0] = sys_clock_control;
        end
        OFS_FAST_RC_CTRL:
        begin
          next_prdata[7:0] = fast_rc_control;
        end
        OFS_IRQ_STATUS:
        begin
          next_prdata[IRQ_W-1:0] = irq_status;
        end
        OFS_IRQ_MASK:
        begin
          next_prdata[IRQ_W-1:0] = irq_mask;
        end
        OFS_CLK_STATE:
        begin
          next_prdata[4:0] = cfg_active;
          next_prdata[13:8] = power_mode;
          next_prdata[17:16] = fast_rc_freq_out;
        end
        default:
        begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers and fast RC stabilisation
  // ----------------------------------------------------------------
  always_comb
  begin
    next_sys_clock_control = sys_clock_control;
    next_fast_rc_osc_enable = fast_rc_osc_enable;
    next_fast_rc_freq_select = fast_rc_freq_select;
    next_irq_mask = irq_mask;
    if (wr_commit && (paddr == OFS_SYS_CLK_CTRL))
    begin
      next_sys_clock_control = pwdata[7:0] & SCC_WMASK;
    end
    if (wr_commit && (paddr == OFS_FAST_RC_CTRL))
    begin
      // The stable flag bit of the write data is dropped here.
      next_fast_rc_freq_select = pwdata[FREQ_HI:FREQ_LO];
      next_fast_rc_osc_enable = pwdata[EN_BIT];
    end
    if (wr_commit && (paddr == OFS_IRQ_MASK))
    begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
    restart = (next_fast_rc_osc_enable && !fast_rc_osc_enable) ||
              (fast_rc_osc_enable && (next_fast_rc_freq_select != fast_rc_freq_select));
    next_settle_cnt = settle_cnt;
    next_fast_rc_stable_flag = fast_rc_stable_flag;
    if (!next_fast_rc_osc_enable)
    begin
      next_settle_cnt = 8'h00;
      next_fast_rc_stable_flag = 1'b0;
    end
    else if (restart)
    begin
      next_settle_cnt = 8'h00;
      next_fast_rc_stable_flag = 1'b0;
    end
    else if (settle_cnt != SETTLE_CNT)
    begin
      next_settle_cnt = 8'(settle_cnt + 8'h01);
    end
    else
    begin
      next_fast_rc_stable_flag = ready_sync;
    end
    next_fast_rc_freq_out = fast_rc_freq_out;
    if (next_fast_rc_stable_flag && !fast_rc_stable_flag)
    begin
      next_fast_rc_freq_out = freq_norm(fast_rc_freq_select);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    events = '0;
    events[IRQ_STABLE] = next_fast_rc_stable_flag && !fast_rc_stable_flag;
    events[IRQ_SWITCH] = switch_done;
    next_irq_status = irq_status;
    if (wr_commit && (paddr == OFS_IRQ_STATUS))
    begin
      next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
    end
    // A new event beats a clear in the same cycle.
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // ----------------------------------------------------------------
  // Power mode and oscillator run controls
  // ----------------------------------------------------------------
  mode_t next_power_mode;
  logic next_cpu_halted, high_on, low_on;
  logic next_fast_rc_osc_run, next_fast_xtal_run, next_slow_rc_run, next_slow_xtal_run;
  logic hkeep, lkeep, hsrc, lsrc;

  assign hkeep = sys_clock_control[HKEEP_BIT];
  assign lkeep = sys_clock_control[LKEEP_BIT];
  assign hsrc = sys_clock_control[HSRC_BIT];
  assign lsrc = sys_clock_control[LSRC_BIT];

  always_comb
  begin
    next_power_mode = power_mode;
    case (power_mode)
      MODE_FAST, MODE_SLOW:
      begin
        if (halt_req)
        begin
          case ({hkeep, lkeep})
            2'b00: next_power_mode = MODE_SLEEP;
            2'b01: next_power_mode = MODE_IDLE0;
            2'b11: next_power_mode = MODE_IDLE1;
            default: next_power_mode = MODE_IDLE2;
          endcase
        end
        else
        begin
          next_power_mode = run_mode(cfg_active[4:2]);
        end
      end
      MODE_IDLE0, MODE_IDLE1, MODE_IDLE2, MODE_SLEEP:
      begin
        if (wake_req)
        begin
          next_power_mode = run_mode(cfg_active[4:2]);
        end
      end
      default:
      begin
        next_power_mode = MODE_FAST;
      end
    endcase
    next_cpu_halted = !((next_power_mode == MODE_FAST) || (next_power_mode == MODE_SLOW));
    high_on = !next_cpu_halted || hkeep;
    low_on = !next_cpu_halted || lkeep;
    // The unselected fast RC still follows its own enable while the CPU runs.
    next_fast_rc_osc_run = fast_rc_osc_enable && (hsrc ? !next_cpu_halted : high_on);
    next_fast_xtal_run = hsrc && high_on;
    next_slow_rc_run = !lsrc && low_on;
    next_slow_xtal_run = lsrc && low_on;
  end

  // ----------------------------------------------------------------
  // Clock selection switcher
  // ----------------------------------------------------------------
  clk_switch u_clk_switch
  (
    .pclk(pclk),
    .presetn(presetn),
    .cfg_req({sys_clock_control[SEL_HI:SEL_LO], hsrc, lsrc}),
    .osc_edge(osc_edge),
    .sys_tick(sys_tick),
    .cfg_active(cfg_active),
    .switch_done(switch_done)
  );

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_clock_control <= SCC_RESET;
      fast_rc_osc_enable <= RC_EN_RESET;
      fast_rc_freq_select <= 2'h0;
      fast_rc_stable_flag <= 1'b0;
      settle_cnt <= 8'h00;
      fast_rc_freq_out <= 2'h0;
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      power_mode <= MODE_FAST;
      cpu_halted <= 1'b0;
      fast_rc_osc_run <= 1'b1;
      fast_xtal_run <= 1'b0;
      slow_rc_run <= 1'b1;
      slow_xtal_run <= 1'b0;
    end
    else
    begin
      sys_clock_control <= next_sys_clock_control;
      fast_rc_osc_enable <= next_fast_rc_osc_enable;
      fast_rc_freq_select <= next_fast_rc_freq_select;
      fast_rc_stable_flag <= next_fast_rc_stable_flag;
      settle_cnt <= next_settle_cnt;
      fast_rc_freq_out <= next_fast_rc_freq_out;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      power_mode <= next_power_mode;
      cpu_halted <= next_cpu_halted;
      fast_rc_osc_run <= next_fast_rc_osc_run;
      fast_xtal_run <= next_fast_xtal_run;
      slow_rc_run <= next_slow_rc_run;
      slow_xtal_run <= next_slow_xtal_run;
    end
  end

endmodule : system_clock_select_and_fast_rc_control
`default_nettype wire

// >>> rtl/clk_ctrl_pkg.sv
// Shared constants, types and helpers for the system clock select and fast RC control block.
// Assumes a single APB clock domain; oscillator clocks arrive as sampled pins.
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYS_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_FAST_RC_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CLK_STATE = 8'h10;

  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int HSRC_BIT = 3;
  localparam int LSRC_BIT = 2;
  localparam int HKEEP_BIT = 1;
  localparam int LKEEP_BIT = 0;
  localparam logic [7:0] SCC_WMASK = 8'hef;
  localparam logic [7:0] SCC_RESET = 8'h00;

  localparam int FREQ_HI = 3;
  localparam int FREQ_LO = 2;
  localparam int FLAG_BIT = 1;
  localparam int EN_BIT = 0;
  localparam logic RC_EN_RESET = 1'b1;

  localparam int IRQ_W = 2;
  localparam int IRQ_STABLE = 0;
  localparam int IRQ_SWITCH = 1;

  localparam logic [2:0] SEL_SUB = 3'h7;
  localparam logic [2:0] SWITCH_CUR_TICKS = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FAST_RC_SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (FAST_RC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CNT = SETTLE_CYC[7:0];

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_FAST = 6'h01,
    MODE_SLOW = 6'h02,
    MODE_IDLE0 = 6'h04,
    MODE_IDLE1 = 6'h08,
    MODE_IDLE2 = 6'h10,
    MODE_SLEEP = 6'h20
  } mode_t;

  typedef enum logic [2:0] {
    SW_RUN = 3'h1,
    SW_COUNT = 3'h2,
    SW_WAIT = 3'h4
  } sw_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mode_t run_mode(input logic [2:0] sel);
    run_mode = (sel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
  endfunction : run_mode

  function automatic logic [1:0] freq_norm(input logic [1:0] code);
    freq_norm = (code == 2'h3) ? 2'h0 : code;
  endfunction : freq_norm

endpackage : clk_ctrl_pkg

// >>> rtl/clk_switch.sv
// Clock selection switcher: divides the chosen source and moves to a new selection.
// Assumes the four oscillator edge strobes are already synchronised to pclk.
`timescale 1ns/100ps
`default_nettype none
module clk_switch
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] cfg_req,
  input wire logic [3:0] osc_edge,
  output logic sys_tick,
  output logic [4:0] cfg_active,
  output logic switch_done
);
  import clk_ctrl_pkg::*;

  sw_state_t state, next_state;
  logic [5:0] div_cnt, next_div_cnt;
  logic [2:0] tick_cnt, next_tick_cnt;
  logic [4:0] next_cfg_active;
  logic next_sys_tick, next_switch_done;
  logic cur_edge, tgt_edge, cur_tick;
  logic [5:0] mask;

  // Config layout is {select[2:0], high source, low source}.
  function automatic logic pick(input logic [4:0] cfg, input logic [3:0] e);
    if (cfg[4:2] == SEL_SUB)
    begin
      pick = cfg[0] ? e[3] : e[2];
    end
    else
    begin
      pick = cfg[1] ? e[1] : e[0];
    end
  endfunction : pick

  always_comb
  begin
    cur_edge = pick(cfg_active, osc_edge);
    tgt_edge = pick(cfg_req, osc_edge);
    mask = (cfg_active[4:2] == SEL_SUB) ? 6'h00 : 6'(~(6'h3f << cfg_active[4:2]));
    cur_tick = cur_edge && ((div_cnt & mask) == mask);
    next_state = state;
    next_div_cnt = cur_edge ? 6'(div_cnt + 6'h01) : div_cnt;
    next_tick_cnt = tick_cnt;
    next_cfg_active = cfg_active;
    next_switch_done = 1'b0;
    next_sys_tick = cur_tick;
    case (state)
      SW_RUN:
      begin
        if (cfg_req != cfg_active)
        begin
          next_state = SW_COUNT;
          next_tick_cnt = 3'h0;
        end
      end
      SW_COUNT:
      begin
        if (cur_tick)
        begin
          next_tick_cnt = 3'(tick_cnt + 3'h1);
          if (next_tick_cnt == SWITCH_CUR_TICKS)
          begin
            next_state = SW_WAIT;
          end
        end
      end
      SW_WAIT:
      begin
        // Changing over on a target edge avoids a runt period on the system clock.
        if (tgt_edge)
        begin
          next_cfg_active = cfg_req;
          next_div_cnt = 6'h00;
          next_switch_done = 1'b1;
          next_state = SW_RUN;
        end
      end
      default:
      begin
        next_state = SW_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SW_RUN;
      div_cnt <= 6'h00;
      tick_cnt <= 3'h0;
      cfg_active <= 5'h00;
      sys_tick <= 1'b0;
      switch_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      cfg_active <= next_cfg_active;
      sys_tick <= next_sys_tick;
      switch_done <= next_switch_done;
    end
  end

endmodule : clk_switch
`default_nettype wire

// >>> tb/clk_ctrl_sva.sv
// Port checker for the system clock select and fast RC control block.
// Assumes one pclk domain with presetn as its reset; bound in below.
`timescale 1ns/100ps
`default_nettype none
module clk_ctrl_sva
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic halt_req,
  input wire logic fast_rc_osc_run,
  input wire logic [1:0] fast_rc_freq_out,
  input wire logic fast_xtal_run,
  input wire logic slow_rc_run,
  input wire logic slow_xtal_run,
  input wire logic cpu_halted,
  input wire clk_ctrl_pkg::mode_t power_mode
);
  import clk_ctrl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Bus and register checks
  // ----------------------------------------------------------------
  property p_one_wait;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("Answer not after one wait state");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("Error without ready");
  property p_rd_sys_zero;
    psel && penable && pready && !pwrite && paddr == OFS_SYS_CLK_CTRL
      |-> prdata[4] == 1'b0 && prdata[31:8] == 24'h0;
  endproperty
  a_rd_sys_zero: assert property (p_rd_sys_zero) else $error("Unused bits read set");
  property p_rd_rc_zero;
    psel && penable && pready && !pwrite && paddr == OFS_FAST_RC_CTRL |-> prdata[31:4] == 28'h0;
  endproperty
  a_rd_rc_zero: assert property (p_rd_rc_zero) else $error("Unused bits read set");
  property p_freq_code;
    fast_rc_freq_out != 2'h3;
  endproperty
  a_freq_code: assert property (p_freq_code) else $error("Applied frequency code invalid");
  // ----------------------------------------------------------------
  // Halt checks
  // ----------------------------------------------------------------
  property p_halt_entry;
    halt_req && !cpu_halted |-> ##[1:2] cpu_halted;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("Halt not entered");
  property p_halted_mode;
    cpu_halted == !(power_mode == MODE_FAST || power_mode == MODE_SLOW);
  endproperty
  a_halted_mode: assert property (p_halted_mode) else $error("Halt flag disagrees");
  property p_sleep_off;
    power_mode == MODE_SLEEP
      |-> !(fast_rc_osc_run || fast_xtal_run || slow_rc_run || slow_xtal_run);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Oscillator runs in sleep");
  property p_idle0;
    power_mode == MODE_IDLE0
      |-> !fast_rc_osc_run && !fast_xtal_run && (slow_rc_run || slow_xtal_run);
  endproperty
  a_idle0: assert property (p_idle0) else $error("Wrong oscillators in idle0");
  property p_idle2;
    power_mode == MODE_IDLE2 |-> !slow_rc_run && !slow_xtal_run;
  endproperty
  a_idle2: assert property (p_idle2) else $error("Slow oscillator runs in idle2");
endmodule : clk_ctrl_sva
bind system_clock_select_and_fast_rc_control clk_ctrl_sva u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
  .fast_rc_osc_run(fast_rc_osc_run), .fast_rc_freq_out(fast_rc_freq_out),
  .fast_xtal_run(fast_xtal_run), .slow_rc_run(slow_rc_run), .slow_xtal_run(slow_xtal_run),
  .cpu_halted(cpu_halted), .power_mode(power_mode));
`default_nettype wire

// >>> tb/system_clock_select_and_fast_rc_control_tb.sv
// Self-checking bench: APB traffic, oscillator pins and halt requests.
// Assumes the package, design and checker files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module system_clock_select_and_fast_rc_control_tb;
  import clk_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, rc_ready;
  logic halt_req, wake_req, sys_tick, rc_run, hx_run, lr_run, lx_run, cpu_halted;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] osc;
  logic [2:0] sel;
  logic [1:0] freq_out, c, src;
  mode_t power_mode;
  int n_errors, n_tests, seed, k, cyc, gap, op, np;
  int hp [4] = '{2, 3, 5, 7};
  int ph [4] = '{default: 0};
  system_clock_select_and_fast_rc_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_fast_rc_osc(osc[0]),
    .external_fast_crystal(osc[1]), .internal_slow_rc_osc(osc[2]),
    .external_slow_crystal(osc[3]), .fast_rc_ready(rc_ready), .halt_req(halt_req),
    .wake_req(wake_req), .sys_tick(sys_tick), .fast_rc_osc_run(rc_run),
    .fast_rc_freq_out(freq_out), .fast_xtal_run(hx_run), .slow_rc_run(lr_run),
    .slow_xtal_run(lx_run), .cpu_halted(cpu_halted), .power_mode(power_mode), .irq(irq));
  // ----------------------------------------------------------------
  // Clock and oscillator pins
  // ----------------------------------------------------------------
  always #10 pclk = ~pclk;
  // Oscillators are whole multiples of pclk so tick spacing is exact.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++)
    begin
      ph[i] <= (ph[i] + 1) % hp[i];
      if (ph[i] == hp[i] - 1)
      begin
        osc[i] <= ~osc[i];
      end
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic bad(input string name);
    n_errors++;
    $display("Error %s expected done seen timeout", name);
    finish_test();
  endtask : bad
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      if (n++ > 20)
      begin
        bad("pready");
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                      input int lim);
    int t0;
    t0 = cyc;
    apb(1'b0, a, 32'h0);
    while ((rd & m) !== v)
    begin
      if (cyc - t0 > lim)
      begin
        bad("poll");
      end
      apb(1'b0, a, 32'h0);
    end
  endtask : poll
  task automatic tick_gap;
    int t0;
    for (int j = 0; j < 2; j++)
    begin
      t0 = cyc;
      @(posedge pclk);
      while (sys_tick !== 1'b1 && cyc - t0 < 2000)
      begin
        @(posedge pclk);
      end
      if (sys_tick !== 1'b1)
      begin
        bad("sys_tick");
      end
    end
    gap = cyc - t0;
  endtask : tick_gap
  task automatic pulse(input bit h);
    if (h)
    begin
      halt_req <= 1'b1;
    end
    else
    begin
      wake_req <= 1'b1;
    end
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse
  function automatic int exp_per(input logic [2:0] s, input logic [1:0] sr);
    if (s == 3'h7)
    begin
      return 2 * hp[sr[0] ? 3 : 2];
    end
    return (2 * hp[sr[1] ? 1 : 0]) << s;
  endfunction : exp_per
  function automatic mode_t exp_mode(input logic [1:0] keep);
    case (keep)
      2'h0: return MODE_SLEEP;
      2'h1: return MODE_IDLE0;
      2'h3: return MODE_IDLE1;
      default: return MODE_IDLE2;
    endcase
  endfunction : exp_mode
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, rc_ready, halt_req, wake_req, osc} = '0;
    {paddr, pwdata, cyc} = '0;
    seed = 86;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rc_run", 32'h1, rc_run);
    apb(1'b0, OFS_SYS_CLK_CTRL, 32'h0);
    chk("sys_ctrl", 32'h0, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_data", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_FAST_RC_CTRL, 32'h0);
    chk("rc_ctrl", 32'h1, rd);
    rc_ready <= 1'b1;
    poll(OFS_FAST_RC_CTRL, 32'h2, 32'h2, 200);
    $display("reset test done");
    for (k = 0; k < 4; k++)
    begin
      c = 2'(k + 1);
      apb(1'b1, OFS_FAST_RC_CTRL, {28'hfffffff, c, 2'h3});
      apb(1'b0, OFS_FAST_RC_CTRL, 32'h0);
      chk("rc_ctrl", {28'h0, c, 2'h1}, rd);
      chk("freq_hold", (k == 3) ? 32'h0 : 32'(k), freq_out);
      poll(OFS_FAST_RC_CTRL, 32'h2, 32'h2, 200);
      chk("freq_out", (c == 2'h3) ? 32'h0 : 32'(c), freq_out);
    end
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk("irq", 32'h1, irq);
    apb(1'b1, OFS_IRQ_STATUS, 32'h3);
    @(posedge pclk);
    chk("irq_clear", 32'h0, irq);
    apb(1'b1, OFS_FAST_RC_CTRL, 32'h0);
    @(posedge pclk);
    chk("rc_off", 32'h0, rc_run);
    apb(1'b1, OFS_FAST_RC_CTRL, 32'h1);
    poll(OFS_FAST_RC_CTRL, 32'h2, 32'h2, 200);
    $display("fast rc test done");
    op = 4;
    for (k = 0; k < 7; k++)
    begin
      sel = (k == 0) ? 3'h7 : (k == 1) ? 3'h0 : 3'($random(seed));
      src = 2'($random(seed));
      np = exp_per(sel, src);
      apb(1'b1, OFS_SYS_CLK_CTRL, {24'h0, sel, 1'b1, src, 2'h0});
      apb(1'b0, OFS_SYS_CLK_CTRL, 32'h0);
      chk("sys_ctrl", {24'h0, sel, 1'b0, src, 2'h0}, rd);
      poll(OFS_CLK_STATE, 32'h1f, {27'h0, sel, src}, 4 * op + np + 30);
      tick_gap();
      chk("period", np, gap);
      op = np;
    end
    $display("switch test done");
    for (k = 0; k < 8; k++)
    begin
      src = k[2] ? 2'h3 : 2'h0;
      apb(1'b1, OFS_SYS_CLK_CTRL, {28'h0, src, 2'(k)});
      poll(OFS_CLK_STATE, 32'h1f, {30'h0, src}, 2000);
      pulse(1'b1);
      chk("mode", exp_mode(2'(k)), power_mode);
      chk("fast_run", k[1], src[1] ? hx_run : rc_run);
      chk("slow_run", k[0], src[0] ? lx_run : lr_run);
      pulse(1'b0);
      chk("wake", MODE_FAST, {cpu_halted, power_mode});
    end
    $display("halt test done");
    finish_test();
  end
endmodule : system_clock_select_and_fast_rc_control_tb
`default_nettype wire
